// ===== hw/cic_irq_ctrl.v
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Six request sources exist: three port 3 pins, two timers and the signal processor.
// - The mask register enables all requests by a global bit and each one by its own bit.
// - Request n vectors through program bytes 2n and 2n+1, which hold the 16-bit handler address.
// - Among several pending enabled requests, a software-set priority register picks the winner.
// - A grant runs a machine cycle that disables interrupts, pushes PC and flags, then jumps.
// - With requests masked, software can poll the request register to see what is pending.
// - Comparator input one feeds request two and comparator input two feeds request zero.
// - Request register bits 7:6 select edges for pins 1 and 2 (FF, FR, RF, both-both).
// - Timer zero end of count raises request four and timer one raises request five.
// - Mask bit 6 set blocks register accesses from 80h to EFh, control registers excepted.
// - Request one comes from pin 3 of port 3 and triggers only on its falling edge.
// - The signal processor sets request three; writing 1 to the control bit clears it, 0 does nothing.
`include "cic_defs.vh"
module cic_irq_ctrl #(
  parameter N = 6
) (
  input wire mclk_i,
  input wire resetn_i,
  input wire port3_pin1_i,
  input wire port3_pin2_i,
  input wire port3_pin3_i,
  input wire comparator_mode_i,
  input wire comparator_input_one_i,
  input wire comparator_input_two_i,
  input wire timer_zero_eoc_i,
  input wire timer_one_eoc_i,
  input wire request_three_dsp_set_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire cpu_ready_i,
  input wire [15:0] cpu_pc_i,
  input wire [7:0] cpu_flags_i,
  input wire [7:0] vec_rdata_i,
  input wire irq_return_i,
  output reg [7:0] reg_rdata_o,
  output reg reg_blocked_o,
  output reg int_cycle_o,
  output reg [15:0] vec_addr_o,
  output reg vec_rd_o,
  output reg stack_push_o,
  output reg [7:0] stack_data_o,
  output reg jump_o,
  output reg [15:0] jump_addr_o,
  output reg [2:0] grant_index_o
);
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  localparam NP = 5;
  wire [NP-1:0] raw_in;
  reg [NP-1:0] sync1_reg;
  reg [NP-1:0] sync2_reg;
  reg [NP-1:0] prev_reg;
  assign raw_in = {comparator_input_two_i, comparator_input_one_i, port3_pin3_i,
                   port3_pin2_i, port3_pin1_i};
  genvar g;
  generate
    for (g = 0; g < NP; g = g + 1) begin : g_sync
      always @(posedge mclk_i) begin
        if (!resetn_i) begin
          sync1_reg[g] <= 1'b1;
          sync2_reg[g] <= 1'b1;
          prev_reg[g] <= 1'b1;
        end else begin
          sync1_reg[g] <= raw_in[g];
          sync2_reg[g] <= sync1_reg[g];
          prev_reg[g] <= sync2_reg[g];
        end
      end
    end
  endgenerate
  wire [NP-1:0] fall = prev_reg & ~sync2_reg;
  wire [NP-1:0] rise = ~prev_reg & sync2_reg;

  // ----------------------------------------
  // Registers and edge decode
  // ----------------------------------------
  reg [7:0] mask_reg;
  reg [7:0] prio_reg;
  reg [5:0] pend_reg;
  reg [5:0] pend_next;
  reg [1:0] edge_sel_reg;
  reg p1_hit;
  reg p2_hit;
  // Comparator mode swaps the pin sources for the analog inputs
  wire [1:0] src_fall = comparator_mode_i ? fall[4:3] : fall[1:0];
  wire [1:0] src_rise = comparator_mode_i ? rise[4:3] : rise[1:0];
  always @* begin
    case (edge_sel_reg)
      `CIC_EDGE_FF: begin
        p1_hit = src_fall[0];
        p2_hit = src_fall[1];
      end
      `CIC_EDGE_FR: begin
        p1_hit = src_fall[0];
        p2_hit = src_rise[1];
      end
      `CIC_EDGE_RF: begin
        p1_hit = src_rise[0];
        p2_hit = src_fall[1];
      end
      default: begin
        p1_hit = src_fall[0] | src_rise[0];
        p2_hit = src_fall[1] | src_rise[1];
      end
    endcase
  end
  // Source map: comparator one/pin1 -> 2, comparator two/pin2 -> 0
  wire [5:0] det = {timer_one_eoc_i, timer_zero_eoc_i, request_three_dsp_set_i,
                    p1_hit, fall[2], p2_hit};

  // Protection window excludes the control registers at F0h and up
  wire in_prot = (reg_addr_i >= `CIC_ADDR_PROT_LO) && (reg_addr_i <= `CIC_ADDR_PROT_HI);
  wire blocked = mask_reg[`CIC_MASK_PROTECT] && in_prot;
  wire wr_ok = reg_wr_i && !blocked;
  wire [5:0] enabled = pend_reg & mask_reg[5:0] & {6{mask_reg[`CIC_MASK_GLOBAL]}};

  // ----------------------------------------
  // Grant state machine
  // ----------------------------------------
  localparam S_IDLE = 3'h0;
  localparam S_PCLO = 3'h1;
  localparam S_PCHI = 3'h2;
  localparam S_FLAG = 3'h3;
  localparam S_VHI = 3'h4;
  localparam S_VLO = 3'h5;
  localparam S_JUMP = 3'h6;
  localparam S_SVC = 3'h7;
  reg [2:0] state_reg;
  reg [2:0] idx_reg;
  reg [7:0] vhi_reg;
  wire found;
  wire [2:0] pick;
  cic_prio_pick #(.N(N)) u_pick (
    .pend_i(enabled),
    .start_i(prio_reg[2:0] % 3'd6),
    .found_o(found),
    .index_o(pick)
  );
  wire grant = (state_reg == S_IDLE) && found && cpu_ready_i;

  always @* begin
    pend_next = pend_reg;
    if (wr_ok && reg_addr_i == `CIC_ADDR_REQ) begin
      pend_next = reg_wdata_i[5:0];
    end
    if (wr_ok && reg_addr_i == `CIC_ADDR_PROC_CTRL && reg_wdata_i[`CIC_PROC_CLR_BIT]) begin
      pend_next[`CIC_REQ_DSP] = 1'b0;
    end
    if (grant) begin
      pend_next[pick] = 1'b0;
    end
    // Set wins over any clear in the same cycle; masking never stops capture
    pend_next = pend_next | det;
  end

  always @(posedge mclk_i) begin
    if (!resetn_i) begin
      mask_reg <= `CIC_RST_MASK;
      prio_reg <= `CIC_RST_PRIO;
      pend_reg <= 6'h00;
      edge_sel_reg <= 2'h0;
      state_reg <= S_IDLE;
      idx_reg <= 3'h0;
      vhi_reg <= 8'h00;
      reg_rdata_o <= 8'h00;
      reg_blocked_o <= 1'b0;
      int_cycle_o <= 1'b0;
      vec_addr_o <= 16'h0000;
      vec_rd_o <= 1'b0;
      stack_push_o <= 1'b0;
      stack_data_o <= 8'h00;
      jump_o <= 1'b0;
      jump_addr_o <= 16'h0000;
      grant_index_o <= 3'h0;
    end else begin
      pend_reg <= pend_next;
      reg_blocked_o <= (reg_wr_i || reg_rd_i) && blocked;
      if (wr_ok && reg_addr_i == `CIC_ADDR_MASK) begin
        mask_reg <= reg_wdata_i;
      end
      if (wr_ok && reg_addr_i == `CIC_ADDR_PRIO) begin
        prio_reg <= reg_wdata_i;
      end
      if (wr_ok && reg_addr_i == `CIC_ADDR_REQ) begin
        edge_sel_reg <= reg_wdata_i[`CIC_REQ_EDGE_HI:`CIC_REQ_EDGE_LO];
      end
      reg_rdata_o <= 8'h00;
      if (reg_rd_i && !blocked) begin
        case (reg_addr_i)
          `CIC_ADDR_REQ: reg_rdata_o <= {edge_sel_reg, pend_reg};
          `CIC_ADDR_MASK: reg_rdata_o <= mask_reg;
          `CIC_ADDR_PRIO: reg_rdata_o <= prio_reg;
          `CIC_ADDR_PROC_CTRL: reg_rdata_o <= {7'h00, pend_reg[`CIC_REQ_DSP]};
          default: reg_rdata_o <= 8'h00;
        endcase
      end
      stack_push_o <= 1'b0;
      vec_rd_o <= 1'b0;
      jump_o <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (grant) begin
            // Interrupts stay off until the handler returns
            int_cycle_o <= 1'b1;
            idx_reg <= pick;
            grant_index_o <= pick;
            stack_push_o <= 1'b1;
            stack_data_o <= cpu_pc_i[7:0];
            state_reg <= S_PCLO;
          end
        end
        S_PCLO: begin
          stack_push_o <= 1'b1;
          stack_data_o <= cpu_pc_i[15:8];
          state_reg <= S_PCHI;
        end
        S_PCHI: begin
          stack_push_o <= 1'b1;
          stack_data_o <= cpu_flags_i;
          state_reg <= S_FLAG;
        end
        S_FLAG: begin
          vec_rd_o <= 1'b1;
          vec_addr_o <= {12'h000, idx_reg, 1'b0};
          state_reg <= S_VHI;
        end
        S_VHI: begin
          vec_rd_o <= 1'b1;
          vec_addr_o <= {12'h000, idx_reg, 1'b1};
          state_reg <= S_VLO;
        end
        S_VLO: begin
          // High byte is valid only one cycle after its fetch strobe
          vhi_reg <= vec_rdata_i;
          state_reg <= S_JUMP;
        end
        S_JUMP: begin
          jump_o <= 1'b1;
          jump_addr_o <= {vhi_reg, vec_rdata_i};
          state_reg <= S_SVC;
        end
        default: begin
          if (irq_return_i) begin
            int_cycle_o <= 1'b0;
            state_reg <= S_IDLE;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== pkg/cic_defs.vh
`ifndef CIC_DEFS_VH
`define CIC_DEFS_VH
// ----------------------------------------
// Register addresses
// ----------------------------------------
`define CIC_ADDR_PRIO 8'hf9
`define CIC_ADDR_REQ 8'hfa
`define CIC_ADDR_MASK 8'hfb
`define CIC_ADDR_PROC_CTRL 8'h0c
`define CIC_ADDR_PROT_LO 8'h80
`define CIC_ADDR_PROT_HI 8'hef
// ----------------------------------------
// Field positions
// ----------------------------------------
`define CIC_MASK_GLOBAL 7
`define CIC_MASK_PROTECT 6
`define CIC_REQ_EDGE_HI 7
`define CIC_REQ_EDGE_LO 6
`define CIC_PROC_CLR_BIT 0
`define CIC_REQ_DSP 3
// ----------------------------------------
// Reset values
// ----------------------------------------
`define CIC_RST_MASK 8'h00
`define CIC_RST_REQ 8'h00
`define CIC_RST_PRIO 8'h00
// ----------------------------------------
// Edge select codes
// ----------------------------------------
`define CIC_EDGE_FF 2'h0
`define CIC_EDGE_FR 2'h1
`define CIC_EDGE_RF 2'h2
`define CIC_EDGE_BB 2'h3
`endif

// ===== hw/cic_prio_pick.v
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Priority pick: rotates the scan start
// ----------------------------------------
module cic_prio_pick #(
  parameter N = 6
) (
  input wire [N-1:0] pend_i,
  input wire [2:0] start_i,
  output reg found_o,
  output reg [2:0] index_o
);
  integer k;
  integer sum;
  reg [3:0] idx;
  always @* begin
    found_o = 1'b0;
    index_o = 3'h0;
    idx = 4'h0;
    sum = 0;
    // Scan from highest offset down so the first in rotation wins last
    for (k = N - 1; k >= 0; k = k - 1) begin
      sum = (start_i + k) % N;
      idx = sum[3:0];
      if (pend_i[idx[2:0]]) begin
        found_o = 1'b1;
        index_o = idx[2:0];
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb/cic_checker.sv
`timescale 1ns/10ps
`default_nettype none
// --------
// Port checker
// --------
module cic_checker (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic cpu_ready_i,
  input wire logic irq_return_i,
  input wire logic reg_rd_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic reg_blocked_o,
  input wire logic int_cycle_o,
  input wire logic [15:0] vec_addr_o,
  input wire logic vec_rd_o,
  input wire logic stack_push_o,
  input wire logic jump_o,
  input wire logic [2:0] grant_index_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_push3;
    stack_push_o [*3];
  endsequence
  // High vector byte first, then its partner
  sequence s_vec2;
    vec_rd_o && vec_addr_o == {12'h000, grant_index_o, 1'b0} ##1
    vec_rd_o && vec_addr_o[0] ##2 jump_o;
  endsequence
  chk_grant_seq: assert property ($rose(int_cycle_o) |-> s_push3 ##1 s_vec2)
    else $error("interrupt cycle out of order");
  chk_grant_ready: assert property ($rose(int_cycle_o) |-> $past(cpu_ready_i))
    else $error("grant without ready");
  chk_hold_service: assert property ($fell(int_cycle_o) |-> $past(irq_return_i))
    else $error("service ended without return");
  chk_index_range: assert property (int_cycle_o |-> grant_index_o < 3'h6)
    else $error("grant index out of range");
  chk_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data outside read");
  chk_block_addr: assert property (reg_blocked_o |->
    $past((reg_rd_i || reg_wr_i) && reg_addr_i >= 8'h80 && reg_addr_i <= 8'hef))
    else $error("block outside protected range");
  chk_block_data: assert property (reg_blocked_o |-> reg_rdata_o == 8'h00)
    else $error("blocked read leaked data");
  chk_jump_pulse: assert property (jump_o |=> !jump_o && !vec_rd_o)
    else $error("jump not a single pulse");
endmodule
bind cic_irq_ctrl cic_checker i_cic_checker (.mclk_i, .resetn_i, .cpu_ready_i, .irq_return_i,
  .reg_rd_i, .reg_wr_i, .reg_addr_i, .reg_rdata_o, .reg_blocked_o, .int_cycle_o,
  .vec_addr_o, .vec_rd_o, .stack_push_o, .jump_o, .grant_index_o);
`default_nettype wire

// ===== tb/cic_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none
// --------
// CPU core and vector memory
// --------
module cic_cpu_model (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic vec_rd_i,
  input wire logic [15:0] vec_addr_i,
  input wire logic jump_i,
  output logic [7:0] vec_rdata_o,
  output logic irq_return_o
);
  logic [4:0] cnt;
  logic slow;
  always @(posedge mclk_i) begin
    irq_return_o <= 1'b0;
    // Released bus flips so stale bytes never match
    vec_rdata_o <= ~vec_rdata_o;
    if (!resetn_i) begin
      cnt <= 5'h00;
      slow <= 1'b0;
      vec_rdata_o <= 8'h00;
    end else begin
      if (vec_rd_i)
        vec_rdata_o <= {4'ha, vec_addr_i[3:0]};
      if (jump_i) begin
        cnt <= slow ? 5'h14 : 5'h02;
        slow <= ~slow;
      end else if (cnt != 5'h00) begin
        cnt <= cnt - 5'h01;
        irq_return_o <= (cnt == 5'h01);
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb/tb_cic_irq_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module tb_cic_irq_ctrl;
  logic mclk_i = 0, resetn_i = 0, p1 = 1, p2 = 1, p3 = 1, cm = 0, c1 = 1, c2 = 1;
  logic t0 = 0, t1 = 0, dsp = 0, wr_s = 0, rd_s = 0, rdy = 0, ret, rd_q = 0;
  logic wr_q = 0, prot = 0;
  logic bq[$];
  logic blk, icyc, vrd, push, jmp;
  logic [2:0] gidx;
  logic [7:0] addr = 0, wdat = 0, flags = 0, vdat, rdata, sdata;
  logic [15:0] pc = 0, vaddr, jaddr;
  logic [31:0] seed = 32'd6535;
  logic [7:0] rq[$], sq[$];
  logic [15:0] jq[$], iq[$];
  int err_total = 0, compares = 0, cyc = 0, s, n;
  always #4 mclk_i = ~mclk_i;
  cic_irq_ctrl i_cic_irq_ctrl (.mclk_i, .resetn_i, .port3_pin1_i(p1), .port3_pin2_i(p2),
    .port3_pin3_i(p3), .comparator_mode_i(cm), .comparator_input_one_i(c1),
    .comparator_input_two_i(c2), .timer_zero_eoc_i(t0), .timer_one_eoc_i(t1),
    .request_three_dsp_set_i(dsp), .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_addr_i(addr),
    .reg_wdata_i(wdat), .cpu_ready_i(rdy), .cpu_pc_i(pc), .cpu_flags_i(flags),
    .vec_rdata_i(vdat), .irq_return_i(ret), .reg_rdata_o(rdata), .reg_blocked_o(blk),
    .int_cycle_o(icyc), .vec_addr_o(vaddr), .vec_rd_o(vrd), .stack_push_o(push),
    .stack_data_o(sdata), .jump_o(jmp), .jump_addr_o(jaddr), .grant_index_o(gidx));
  cic_cpu_model i_cic_cpu_model (.mclk_i, .resetn_i, .vec_rd_i(vrd), .vec_addr_i(vaddr),
    .jump_i(jmp), .vec_rdata_o(vdat), .irq_return_o(ret));
  // --------
  // Helpers
  // --------
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task chk(input string nm, input logic [15:0] sn, input logic [15:0] ex);
    compares++;
    if (sn !== ex) begin
      err_total++;
      $display("Error %s exp %h seen %h", nm, ex, sn);
    end
  endtask
  task stop_test;
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Protected window answers with a block pulse, control registers stay open
  task wr(input logic [7:0] a, input logic [7:0] d);
    bq.push_back(prot && a >= 8'h80 && a <= 8'hef);
    @(posedge mclk_i);
    wr_s <= 1'b1;
    addr <= a;
    wdat <= d;
    @(posedge mclk_i);
    wr_s <= 1'b0;
    if (a == 8'hfb) prot = d[6];
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    rq.push_back(e);
    bq.push_back(prot && a >= 8'h80 && a <= 8'hef);
    @(posedge mclk_i);
    rd_s <= 1'b1;
    addr <= a;
    @(posedge mclk_i);
    rd_s <= 1'b0;
  endtask
  // Idle sources sit high so a mode switch makes no edge
  task lvl(input logic v);
    @(posedge mclk_i);
    p1 <= cm | v;
    p2 <= cm | v;
    c1 <= ~cm | v;
    c2 <= ~cm | v;
    p3 <= v;
    repeat (6) @(posedge mclk_i);
  endtask
  // --------
  // Result watcher
  // --------
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    rd_q <= rd_s;
    wr_q <= wr_s;
    if (rd_q) chk("rdata", 16'(rdata), 16'(rq.pop_front()));
    if (rd_q || wr_q) chk("blocked", 16'(blk), 16'(bq.pop_front()));
    if (push) chk("stack", 16'(sdata), 16'(sq.pop_front()));
    if (jmp) chk("jump", jaddr, jq.pop_front());
    if (jmp) chk("index", 16'(gidx), iq.pop_front());
    if (cyc == 5000) begin
      err_total++;
      stop_test();
    end
  end
  // --------
  // Main sequence
  // --------
  initial begin
    repeat (20) @(posedge mclk_i);
    resetn_i <= 1'b1;
    rd(8'hfb, 8'h00);
    rd(8'hfa, 8'h00);
    @(posedge mclk_i);
    {t0, t1, dsp} <= 3'h7;
    @(posedge mclk_i);
    {t0, t1, dsp} <= 3'h0;
    rd(8'hfa, 8'h38);
    rd(8'h0c, 8'h01);
    wr(8'h0c, 8'h00);
    rd(8'hfa, 8'h38);
    wr(8'h0c, 8'h01);
    rd(8'hfa, 8'h30);
    for (int c = 0; c < 4; c++) begin
      cm <= c[0];
      wr(8'hfa, {c[1:0], 6'h00});
      lvl(1'b0);
      rd(8'hfa, {c[1:0], 3'h0, c != 2, 1'b1, c != 1});
      wr(8'hfa, {c[1:0], 6'h00});
      lvl(1'b1);
      rd(8'hfa, {c[1:0], 3'h0, c > 1, 1'b0, c[0]});
    end
    seed = xs(seed);
    pc <= seed[15:0];
    flags <= seed[23:16];
    s = seed[31:29] % 6;
    wr(8'hf9, 8'(s));
    wr(8'hfb, 8'h3f);
    wr(8'hfa, 8'h3f);
    rd(8'hfa, 8'h3f);
    wr(8'hfb, 8'hbe);
    repeat (10) @(posedge mclk_i);
    rd(8'hfa, 8'h3f);
    for (int k = 0; k < 6; k++) begin
      n = (s + k) % 6;
      if (n != 0) begin
        iq.push_back(16'(n));
        jq.push_back({4'ha, 3'(n), 1'b0, 4'ha, 3'(n), 1'b1});
        sq = {sq, pc[7:0], pc[15:8], flags};
      end
    end
    rdy <= 1'b1;
    for (int t = 0; t < 3000 && jq.size() > 0; t++) @(posedge mclk_i);
    repeat (30) @(posedge mclk_i);
    rd(8'hfa, 8'h01);
    wr(8'hfb, 8'h7f);
    wr(8'hfa, 8'h3f);
    rd(8'hfa, 8'h3f);
    wr(8'h90, 8'h5a);
    rd(8'h90, 8'h00);
    rd(8'hfb, 8'h7f);
    repeat (3) @(posedge mclk_i);
    stop_test();
  end
endmodule
`default_nettype wire
